// ---- verilog/uhrss_pkg.sv ----
// Package with register map, field positions and reset values of the run/stop block.
`default_nettype none
package uhrss_pkg;
	localparam logic [7:0] CMD_STATUS_OFS = 8'h2c;
	localparam logic [7:0] IRQ_STATUS_OFS = 8'h30;
	localparam logic [7:0] IRQ_MASK_OFS   = 8'h34;
	localparam int HALTED_BIT   = 19;
	localparam int RUN_STOP_BIT = 18;
	localparam int OVR_LSB      = 16;
	localparam int IRQ_HALT_BIT = 0;
	localparam int IRQ_OVR_BIT  = 1;
	localparam logic       RUN_STOP_RST = 1'b0;
	localparam logic       HALTED_RST   = 1'b1;
	localparam logic [1:0] OVR_CNT_RST  = 2'h0;
	localparam logic [1:0] IRQ_RST      = 2'h0;
	localparam logic [3:0] STOP_DRAIN_RST = 4'h0;
	typedef enum logic [1:0] {
		UHRSS_HALTED   = 2'b00,
		UHRSS_RUNNING  = 2'b01,
		UHRSS_STOPPING = 2'b10
	} uhrss_state_t;
endpackage
`default_nettype wire

// ---- verilog/uhrss_if.sv ----
// Interface between the register bank and the run/stop sequencer.
`timescale 1ns/100ps
`default_nettype none
interface uhrss_if;
	logic         run_stop_control;
	logic         halted_flag;
	logic         halt_event;
	modport bank (output run_stop_control, input halted_flag, input halt_event);
	modport seq  (input run_stop_control, output halted_flag, output halt_event);
endinterface
`default_nettype wire

// ---- verilog/uhrss_seq.sv ----
// Run/stop sequencer that tracks when the host engine has really stopped.
`timescale 1ns/100ps
`default_nettype none
module uhrss_seq
(
	input  wire logic clock,
	input  wire logic nrst,
	input  wire logic engine_idle,
	uhrss_if.seq      ctl
);
	typedef struct packed {
		uhrss_pkg::uhrss_state_t st;
		logic                    halted;
		logic                    halt_ev;
	} uhrss_seq_t;

	uhrss_seq_t s_q;
	uhrss_seq_t s_d;

	always_comb
	begin
		s_d = s_q;
		s_d.halt_ev = 1'b0;
		unique case (s_q.st)
			uhrss_pkg::UHRSS_HALTED:
			begin
				if (ctl.run_stop_control)
				begin
					s_d.st = uhrss_pkg::UHRSS_RUNNING;
					s_d.halted = 1'b0;
				end
			end
			uhrss_pkg::UHRSS_RUNNING:
			begin
				if (!ctl.run_stop_control)
					s_d.st = uhrss_pkg::UHRSS_STOPPING;
			end
			uhrss_pkg::UHRSS_STOPPING:
			begin
				if (ctl.run_stop_control)
					s_d.st = uhrss_pkg::UHRSS_RUNNING;
				else if (engine_idle)
				begin
					s_d.st = uhrss_pkg::UHRSS_HALTED;
					s_d.halted = 1'b1;
					s_d.halt_ev = 1'b1;
				end
			end
			default:
				s_d.st = uhrss_pkg::UHRSS_HALTED;
		endcase
		if (ctl.run_stop_control)
			s_d.halted = 1'b0;
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			s_q.st <= uhrss_pkg::UHRSS_HALTED;
			s_q.halted <= uhrss_pkg::HALTED_RST;
			s_q.halt_ev <= 1'b0;
		end
		else
			s_q <= s_d;
	end

	// The stored flag clears one clock after run rises, so it is masked with run here.
	// Otherwise a read straight after setting run would show halted and run together.
	assign ctl.halted_flag = s_q.halted & ~ctl.run_stop_control;
	assign ctl.halt_event = s_q.halt_ev;
endmodule // uhrss_seq
`default_nettype wire

// ---- verilog/uhrss_top.sv ----
// Command and status register bank with run/stop control, halted flag and overrun count.
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module uhrss_top
(
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        engine_idle,
	input  wire logic        sched_overrun,
	output logic             run_stop_control,
	output logic             halted_flag,
	output logic             irq
);
	typedef struct packed {
		logic        run;
		logic [1:0]  ovr_cnt;
		logic [1:0]  irq_sts;
		logic [1:0]  irq_mask;
		logic [31:0] rdata;
		logic        irq;
		logic        halted;
		logic [1:0]  idle_sync;
		logic [1:0]  ovr_sync;
		logic        ovr_prev;
	} uhrss_top_t;

	uhrss_top_t r_q;
	uhrss_top_t r_d;
	uhrss_if    ctl ();

	uhrss_seq u_seq
	(
		.clock       (clock),
		.nrst        (nrst),
		.engine_idle (r_q.idle_sync[1]),
		.ctl         (ctl.seq)
	);

	assign ctl.run_stop_control = r_q.run;

	function automatic logic [31:0] cmd_word(input logic run, input logic halted,
		input logic [1:0] cnt);
		logic [31:0] w;
		w = 32'h0;
		w[uhrss_pkg::HALTED_BIT] = halted;
		w[uhrss_pkg::RUN_STOP_BIT] = run;
		w[uhrss_pkg::OVR_LSB +: 2] = cnt;
		return w;
	endfunction

	always_comb
	begin
		logic ovr_pulse;
		ovr_pulse = 1'b0;
		r_d = r_q;
		r_d.idle_sync = {r_q.idle_sync[0], engine_idle};
		r_d.ovr_sync = {r_q.ovr_sync[0], sched_overrun};
		r_d.ovr_prev = r_q.ovr_sync[1];
		ovr_pulse = r_q.ovr_sync[1] & ~r_q.ovr_prev;
		r_d.rdata = 32'h0;
		if (reg_rd)
		begin
			unique case (reg_addr)
				uhrss_pkg::CMD_STATUS_OFS:
					r_d.rdata = cmd_word(r_q.run, ctl.halted_flag, r_q.ovr_cnt);
				uhrss_pkg::IRQ_STATUS_OFS:
				begin
					r_d.rdata = {30'h0, r_q.irq_sts};
					r_d.irq_sts = 2'h0;
				end
				uhrss_pkg::IRQ_MASK_OFS:
					r_d.rdata = {30'h0, r_q.irq_mask};
				default:
					r_d.rdata = 32'h0;
			endcase
		end
		if (reg_wr)
		begin
			unique case (reg_addr)
				uhrss_pkg::CMD_STATUS_OFS:
					r_d.run = reg_wdata[uhrss_pkg::RUN_STOP_BIT];
				uhrss_pkg::IRQ_MASK_OFS:
					r_d.irq_mask = reg_wdata[1:0];
				default:
					r_d.run = r_q.run;
			endcase
		end
		// Masked with the next run value so that the pin never shows halted beside run.
		r_d.halted = ctl.halted_flag & ~r_d.run;
		if (ovr_pulse)
		begin
			r_d.ovr_cnt = r_q.ovr_cnt + 2'h1;
			r_d.irq_sts[uhrss_pkg::IRQ_OVR_BIT] = 1'b1;
		end
		// Hardware set wins over the clear-on-read in the same cycle.
		if (ctl.halt_event)
			r_d.irq_sts[uhrss_pkg::IRQ_HALT_BIT] = 1'b1;
		r_d.irq = |(r_d.irq_sts & r_d.irq_mask);
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			r_q.run <= uhrss_pkg::RUN_STOP_RST;
			r_q.ovr_cnt <= uhrss_pkg::OVR_CNT_RST;
			r_q.irq_sts <= uhrss_pkg::IRQ_RST;
			r_q.irq_mask <= uhrss_pkg::IRQ_RST;
			r_q.rdata <= 32'h0;
			r_q.irq <= 1'b0;
			r_q.halted <= uhrss_pkg::HALTED_RST;
			r_q.idle_sync <= 2'h0;
			r_q.ovr_sync <= 2'h0;
			r_q.ovr_prev <= 1'b0;
		end
		else
			r_q <= r_d;
	end

	assign reg_rdata = r_q.rdata;
	assign run_stop_control = r_q.run;
	assign halted_flag = r_q.halted;
	assign irq = r_q.irq;
endmodule // uhrss_top
`default_nettype wire

// ---- verification/uhrss_chk.sv ----
// Port checker of the run/stop register bank.
`timescale 1ns/100ps
`default_nettype none
module uhrss_chk
(
	input wire logic        clock,
	input wire logic        nrst,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        engine_idle,
	input wire logic        run_stop_control,
	input wire logic        halted_flag
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);
	sequence cmd_rd;
		reg_rd && reg_addr == uhrss_pkg::CMD_STATUS_OFS;
	endsequence
	sequence cmd_wr;
		reg_wr && reg_addr == uhrss_pkg::CMD_STATUS_OFS;
	endsequence
	chk_halt_excl: assert property (!(reg_rdata[19] && reg_rdata[18]))
		else $error("halted read with run set");
	chk_halt_done: assert property ((!run_stop_control && engine_idle)[*8] |-> halted_flag)
		else $error("halted missing after stop");
	chk_halt_cause: assert property ($rose(halted_flag) |-> !run_stop_control
		&& $past(engine_idle, 4))
		else $error("halted set too early");
	chk_run_write: assert property (cmd_wr |=> run_stop_control == $past(reg_wdata[18]))
		else $error("run bit not written");
	chk_cmd_fields: assert property (cmd_rd |=> reg_rdata[31:20] == 12'h000
		&& reg_rdata[15:0] == 16'h0000)
		else $error("spare bits set");
endmodule // uhrss_chk
bind uhrss_top uhrss_chk u_uhrss_chk (.clock, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .engine_idle, .run_stop_control, .halted_flag);
`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking bench of the run/stop register bank.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic        clock, nrst, reg_wr, reg_rd, engine_idle, sched_overrun;
	logic        run_stop_control, halted_flag, irq;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	int          n_errors = 0;
	int          samples_checked = 0;
	// Row: engine idle, run bit written, expected command word.
	logic [33:0] rows [4] = '{{2'b01, 32'h00040000}, {2'b00, 32'h0}, {2'b10, 32'h00080000},
		{2'b11, 32'h00040000}};
	uhrss_top u_uhrss_top (.clock, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.engine_idle, .sched_overrun, .run_stop_control, .halted_flag, .irq);
	task automatic cyc(int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic chk(logic [31:0] v, logic [31:0] e);
		samples_checked++;
		if (v !== e)
		begin
			$display("wrong value at %0t: got %h want %h", $time, v, e);
			n_errors++;
		end
	endtask
	task automatic wreg(logic [7:0] a, logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	// Read data stand one cycle and are sampled at the edge that ends it.
	task automatic rchk(logic [7:0] a, logic [31:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(posedge clock);
		chk(reg_rdata, e);
	endtask
	task automatic complete_run;
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	initial
	begin
		cyc(2000);
		n_errors++;
		complete_run;
	end
	initial
	begin
		{nrst, reg_wr, reg_rd, engine_idle, sched_overrun, reg_addr, reg_wdata} <= '0;
		cyc(3);
		nrst <= 1'b1;
		rchk(uhrss_pkg::CMD_STATUS_OFS, 32'h00080000);
		foreach (rows[i])
		begin
			engine_idle <= rows[i][33];
			wreg(uhrss_pkg::CMD_STATUS_OFS, {13'h0, rows[i][32], 18'h0});
			cyc(8);
			rchk(uhrss_pkg::CMD_STATUS_OFS, rows[i][31:0]);
			chk({30'h0, halted_flag, run_stop_control}, {30'h0, rows[i][19:18]});
		end
		// Stop, then set run and read back at once: the lagging halted bit must not show.
		wreg(uhrss_pkg::CMD_STATUS_OFS, 32'h0);
		cyc(8);
		chk({31'h0, halted_flag}, 32'h1);
		wreg(uhrss_pkg::CMD_STATUS_OFS, 32'h00040000);
		rchk(uhrss_pkg::CMD_STATUS_OFS, 32'h00040000);
		chk({30'h0, halted_flag, run_stop_control}, 32'h1);
		repeat (5)
		begin
			sched_overrun <= 1'b1;
			cyc(3);
			sched_overrun <= 1'b0;
			cyc(3);
		end
		cyc(3);
		rchk(uhrss_pkg::CMD_STATUS_OFS, 32'h00050000);
		chk({31'h0, irq}, 32'h0);
		wreg(uhrss_pkg::IRQ_MASK_OFS, 32'h3);
		cyc(2);
		chk({31'h0, irq}, 32'h1);
		rchk(uhrss_pkg::IRQ_STATUS_OFS, 32'h3);
		rchk(uhrss_pkg::IRQ_STATUS_OFS, 32'h0);
		chk({31'h0, irq}, 32'h0);
		rchk(8'h40, 32'h0);
		// Reset in mid-run must bring back the stopped state and an empty count.
		nrst <= 1'b0;
		cyc(2);
		nrst <= 1'b1;
		rchk(uhrss_pkg::CMD_STATUS_OFS, 32'h00080000);
		chk({31'h0, irq}, 32'h0);
		complete_run;
	end
endmodule // testbench
`default_nettype wire
